// ---- rtl/qdac_ctrl.sv ----
// Top of the quad converter control: pin link, double-buffered code registers, bus slave.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module qdac_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frame_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  input wire logic [qdac_pkg::ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [qdac_pkg::DATA_BITS-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [qdac_pkg::DATA_BITS-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [qdac_pkg::RESOLUTION-1:0] code_a,
  output logic [qdac_pkg::RESOLUTION-1:0] code_b,
  output logic [qdac_pkg::RESOLUTION-1:0] code_c,
  output logic [qdac_pkg::RESOLUTION-1:0] code_d,
  output logic [qdac_pkg::CHANNELS-1:0] out_enable,
  output logic normal_mode
);
  typedef logic [qdac_pkg::RESOLUTION-1:0] code_t;

  logic [2:0] pins_s;
  logic word_valid;
  logic [qdac_pkg::WORD_BITS-1:0] word;
  logic busy;

  code_t inreg_q [qdac_pkg::CHANNELS];
  code_t inreg_d [qdac_pkg::CHANNELS];
  code_t hold_q [qdac_pkg::CHANNELS];
  code_t hold_d [qdac_pkg::CHANNELS];
  logic [qdac_pkg::CHANNELS-1:0] dirty_q, dirty_d;
  logic [qdac_pkg::CHANNELS-1:0] oe_q, oe_d;
  logic normal_q, normal_d;
  logic [qdac_pkg::COUNT_BITS-1:0] frames_q, frames_d;

  logic enable_q, enable_d;
  logic wait_q, wait_d;
  logic [qdac_pkg::DATA_BITS-1:0] rdata_q, rdata_d;

  // Extracts the data field; narrower builds drop the low-order bits.
  function automatic code_t word_code(input logic [qdac_pkg::WORD_BITS-1:0] w);
    word_code = w[qdac_pkg::DATA_MSB_POS -: qdac_pkg::RESOLUTION];
  endfunction

  // Frame select and serial clock idle high, so their stages reset high; this avoids a
  // false frame start or a false clock fall right after reset.
  qdac_bit_sync #(
    .WIDTH(3),
    .RST_VAL(3'h6)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({frame_n_pin, sclk_pin, din_pin}),
    .pin_sync(pins_s)
  );

  qdac_shifter u_shifter (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclk_s(pins_s[1]),
    .din_s(pins_s[0]),
    .frame_n_s(pins_s[2]),
    .link_enable(enable_q),
    .word_valid(word_valid),
    .word(word),
    .busy(busy)
  );

  // Word commit. Holding registers only follow input registers that changed since the
  // last update, which avoids needless output glitches on unchanged channels.
  always_comb begin
    logic [1:0] ch;
    ch = 2'h0;
    inreg_d = inreg_q;
    hold_d = hold_q;
    dirty_d = dirty_q;
    normal_d = normal_q;
    frames_d = frames_q;
    if (word_valid) begin
      ch = word[qdac_pkg::CHSEL_HI_POS:qdac_pkg::CHSEL_LO_POS];
      inreg_d[ch] = word_code(word);
      dirty_d[ch] = 1'b1;
      normal_d = word[qdac_pkg::SLEEP_POS];
      frames_d = frames_q + 8'h01;
      if (!word[qdac_pkg::UPDATE_POS]) begin
        for (int i = 0; i < qdac_pkg::CHANNELS; i++) begin
          if (dirty_d[i]) begin
            hold_d[i] = inreg_d[i];
          end
        end
        dirty_d = '0;
      end
    end
    // All four outputs go high-impedance together in sleep.
    oe_d = {qdac_pkg::CHANNELS{normal_d}};
  end

  // Power-on state is normal operation with zero codes everywhere.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < qdac_pkg::CHANNELS; i++) begin
        inreg_q[i] <= qdac_pkg::CODE_RST;
        hold_q[i] <= qdac_pkg::CODE_RST;
      end
      dirty_q <= '0;
      oe_q <= {qdac_pkg::CHANNELS{qdac_pkg::NORMAL_RST}};
      normal_q <= qdac_pkg::NORMAL_RST;
      frames_q <= '0;
    end else begin
      inreg_q <= inreg_d;
      hold_q <= hold_d;
      dirty_q <= dirty_d;
      oe_q <= oe_d;
      normal_q <= normal_d;
      frames_q <= frames_d;
    end
  end

  // Only the holding registers reach the converter outputs.
  assign code_a = hold_q[0];
  assign code_b = hold_q[1];
  assign code_c = hold_q[2];
  assign code_d = hold_q[3];
  assign out_enable = oe_q;
  assign normal_mode = normal_q;

  // Bus slave. Every access sees one cycle of waitrequest, then completes; this
  // costs a cycle but keeps readdata and waitrequest straight from flip-flops.
  always_comb begin
    logic req;
    logic [3:0] idx;
    req = avs_read | avs_write;
    idx = 4'h0;
    wait_d = ~(req & wait_q);
    enable_d = enable_q;
    rdata_d = rdata_q;
    if (req && wait_q) begin
      rdata_d = '0;
      if (avs_address == qdac_pkg::CTRL_OFS) begin
        rdata_d[qdac_pkg::CTRL_ENABLE_POS] = enable_q;
      end else if (avs_address == qdac_pkg::STATUS_OFS) begin
        rdata_d[qdac_pkg::STATUS_NORMAL_POS] = normal_q;
        rdata_d[qdac_pkg::STATUS_BUSY_POS] = busy;
        rdata_d[qdac_pkg::STATUS_COUNT_LSB +: qdac_pkg::COUNT_BITS] = frames_q;
      end else if (avs_address >= qdac_pkg::HOLD_BASE_OFS
                   && avs_address < qdac_pkg::INPUT_BASE_OFS) begin
        idx = 4'((avs_address - qdac_pkg::HOLD_BASE_OFS) >> 2);
        rdata_d[qdac_pkg::RESOLUTION-1:0] = hold_q[idx[1:0]];
      end else if (avs_address >= qdac_pkg::INPUT_BASE_OFS
                   && avs_address < (qdac_pkg::INPUT_BASE_OFS + 6'h10)) begin
        idx = 4'((avs_address - qdac_pkg::INPUT_BASE_OFS) >> 2);
        rdata_d[qdac_pkg::RESOLUTION-1:0] = inreg_q[idx[1:0]];
      end
    end
    if (avs_write && !wait_q && avs_address == qdac_pkg::CTRL_OFS && avs_byteenable[0]) begin
      enable_d = avs_writedata[qdac_pkg::CTRL_ENABLE_POS];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
      enable_q <= qdac_pkg::CTRL_ENABLE_RST;
      rdata_q <= '0;
    end else begin
      wait_q <= wait_d;
      enable_q <= enable_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule

// ---- rtl/qdac_pkg.sv ----
// Constants, register map and frame layout for the quad converter serial control block.
// How it works
// - Sixteen-bit input shift register, loaded by serial clock.
// - Frame is four control bits plus data.
// - Word arrives most significant bit first.
// - Top two bits pick the target channel.
// - Bit 13 selects sleep or normal operation.
// - Bit 12 controls when holding registers update.
// - Reset clears input and holding registers.
// - After reset: normal operation, zero codes.
// - Sleep turns off all four outputs together.
// - Holding codes are plain unsigned binary.
// - Holding register, not input register, drives output.
// - Frame select high ignores clock and data.
// - One bit per falling clock, sixteen edges.
// - Early frame select rise aborts, nothing changes.
// - Sleep bit zero powers down, one normal.
// - Update bit zero copies all; one loads the input register only.
package qdac_pkg;
  localparam int WORD_BITS = 16;
  localparam int RESOLUTION = 12;
  localparam int CHANNELS = 4;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0F;

  // Field positions inside the received word.
  localparam int CHSEL_HI_POS = 15;
  localparam int CHSEL_LO_POS = 14;
  localparam int SLEEP_POS = 13;
  localparam int UPDATE_POS = 12;
  localparam int DATA_MSB_POS = 11;

  // Bus layout.
  localparam int ADDR_BITS = 6;
  localparam int DATA_BITS = 32;
  localparam logic [ADDR_BITS-1:0] CTRL_OFS = 6'h00;
  localparam logic [ADDR_BITS-1:0] STATUS_OFS = 6'h04;
  localparam logic [ADDR_BITS-1:0] HOLD_BASE_OFS = 6'h08;
  localparam logic [ADDR_BITS-1:0] INPUT_BASE_OFS = 6'h18;
  localparam int CTRL_ENABLE_POS = 0;
  localparam int STATUS_NORMAL_POS = 0;
  localparam int STATUS_BUSY_POS = 1;
  localparam int STATUS_COUNT_LSB = 8;
  localparam int COUNT_BITS = 8;

  // Reset values.
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic NORMAL_RST = 1'b1;
  localparam logic [RESOLUTION-1:0] CODE_RST = 12'h000;
endpackage

// ---- rtl/qdac_bit_sync.sv ----
// Two-flop synchroniser for pin inputs coming from outside the clock domain.
`timescale 1ns/1ps
module qdac_bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule

// ---- rtl/qdac_shifter.sv ----
// Frame receiver: finds serial clock falls and assembles one sixteen-bit word.
`timescale 1ns/1ps
module qdac_shifter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk_s,
  input wire logic din_s,
  input wire logic frame_n_s,
  input wire logic link_enable,
  output logic word_valid,
  output logic [qdac_pkg::WORD_BITS-1:0] word,
  output logic busy
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    SHIFT = 3'b010,
    DONE = 3'b100
  } rx_state_t;

  rx_state_t state_q, state_d;
  logic [qdac_pkg::WORD_BITS-1:0] shift_q, shift_d;
  logic [qdac_pkg::CNT_BITS-1:0] cnt_q, cnt_d;
  logic sclk_prev_q, sclk_prev_d;
  logic valid_q, valid_d;
  logic fall;

  assign fall = sclk_prev_q & ~sclk_s;

  // Next state. Once sixteen bits are in, further edges are ignored until a new frame.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    sclk_prev_d = sclk_s;
    valid_d = 1'b0;
    unique case (state_q)
      IDLE: begin
        if (!frame_n_s && link_enable) begin
          state_d = SHIFT;
          cnt_d = '0;
        end
      end
      SHIFT: begin
        if (frame_n_s) begin
          state_d = IDLE;
        end else if (fall) begin
          shift_d = {shift_q[qdac_pkg::WORD_BITS-2:0], din_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == qdac_pkg::LAST_BIT) begin
            state_d = DONE;
            valid_d = 1'b1;
          end
        end
      end
      DONE: begin
        if (frame_n_s) begin
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  // The shift register keeps the last word, so the word output is stable with the pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= IDLE;
      shift_q <= '0;
      cnt_q <= '0;
      sclk_prev_q <= 1'b1; // Serial clock idles high, so no false fall follows reset.
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      sclk_prev_q <= sclk_prev_d;
      valid_q <= valid_d;
    end
  end

  assign word_valid = valid_q;
  assign word = shift_q;
  assign busy = (state_q == SHIFT);
endmodule

// ---- verif/qdac_ctrl_checker.sv ----
// Concurrent checks on the pins and bus of the quad converter control block.
`timescale 1ns/1ps
module qdac_ctrl_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frame_n_pin,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [11:0] code_a,
  input wire logic [11:0] code_b,
  input wire logic [11:0] code_c,
  input wire logic [11:0] code_d,
  input wire logic [3:0] out_enable,
  input wire logic normal_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // All four codes side by side, so one stability check covers every channel.
  wire logic [47:0] codes = {code_a, code_b, code_c, code_d};
  reset_state_a: assert property ($fell(sys_rst) |-> codes == 48'h0 && normal_mode)
    else $error("outputs not cleared by reset");
  sleep_outputs_a: assert property (out_enable == {4{normal_mode}})
    else $error("output enables disagree with mode");
  idle_codes_a: assert property (frame_n_pin [*8] |=> $stable(codes))
    else $error("codes moved while not selected");
  idle_mode_a: assert property (frame_n_pin [*8] |=> $stable(normal_mode))
    else $error("mode moved while not selected");
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  hold_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h08
    |-> avs_readdata[11:0] == code_a)
    else $error("holding readback differs from code");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h30
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios seen at least once.
  cover property ($fell(normal_mode));
  cover property ($changed(code_d));
  cover property (avs_read && !avs_waitrequest);
endmodule

bind qdac_ctrl qdac_ctrl_checker chk_i (.clk(clk), .sys_rst(sys_rst), .frame_n_pin(frame_n_pin),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .code_a(code_a),
  .code_b(code_b), .code_c(code_c), .code_d(code_d), .out_enable(out_enable),
  .normal_mode(normal_mode));

// ---- verif/host_link.sv ----
// Host model that drives the three-wire serial link of the converter.
`timescale 1ns/1ps
module host_link (
  input wire logic clk,
  output logic frame_n,
  output logic sclk,
  output logic din
);
  // Idle: not selected, clock parked high and still.
  initial begin
    frame_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Each phase lasts four system clocks, a 400 ns serial period.
  task automatic send(input logic [15:0] w, input int falls);
    frame_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < falls; i++) begin
      din <= w[15 - i];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    // A short count raises select early and aborts the frame.
    frame_n <= 1'b1;
    din <= ~din; // Released line shows no stale bit.
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- verif/quad_dac_serial_control_bench.sv ----
// Self-checking bench for the quad converter control block.
`timescale 1ns/1ps
module quad_dac_serial_control_bench;
  typedef struct packed {logic [15:0] w; logic [47:0] c; logic n;} row_t;
  logic clk, sys_rst, frame_n_pin, sclk_pin, din_pin, avs_read, avs_write;
  logic avs_waitrequest, normal_mode;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] code_a, code_b, code_c, code_d;
  logic [3:0] out_enable;
  int bad_count, tests_run;
  // Each row: word sent, expected codes A..D, expected mode.
  row_t rows [5] = '{'{16'h3123, 48'h000000000000, 1'b1},
    '{16'h6456, 48'h123456000000, 1'b1}, '{16'hA789, 48'h123456789000, 1'b1},
    '{16'hCABC, 48'h123456789ABC, 1'b0}, '{16'h3FFF, 48'h123456789ABC, 1'b1}};

  qdac_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .frame_n_pin(frame_n_pin), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .code_a(code_a), .code_b(code_b), .code_c(code_c),
    .code_d(code_d), .out_enable(out_enable), .normal_mode(normal_mode));
  host_link host (.clk(clk), .frame_n(frame_n_pin), .sclk(sclk_pin), .din(din_pin));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // A request that never completes is a mismatch and ends the run.
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      final_report();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic outs(input logic [47:0] c, input logic n);
    chk("codes", {code_a, code_b, code_c, code_d}, c);
    chk("mode", 48'(normal_mode), 48'(n));
    chk("enables", 48'(out_enable), 48'({4{n}}));
  endtask

  // Main sequence: table of frames, then abort, disabled link, bus edges, reset.
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    outs(48'h0, 1'b1);
    foreach (rows[i]) begin
      host.send(rows[i].w, 16);
      outs(rows[i].c, rows[i].n);
      bus(1'b0, 6'h18 + {2'h0, rows[i].w[15:14], 2'h0}, 32'h0);
      chk("input", 48'(rd), 48'(rows[i].w[11:0]));
    end
    host.send(16'h0000, 15);
    outs(rows[4].c, 1'b1);
    bus(1'b0, 6'h18, 32'h0);
    chk("aborted input", 48'(rd), 48'hFFF);
    bus(1'b1, 6'h00, 32'h0);
    host.send(16'h0000, 16);
    outs(rows[4].c, 1'b1);
    bus(1'b1, 6'h00, 32'h1);
    bus(1'b0, 6'h30, 32'h0);
    chk("unmapped", 48'(rd), 48'h0);
    bus(1'b0, 6'h08, 32'h0);
    chk("holding a", 48'(rd), 48'h123);
    bus(1'b0, 6'h00, 32'h0);
    chk("link enable", 48'(rd), 48'h1);
    // Five table frames completed; the aborted and the ignored frame are not counted.
    bus(1'b0, 6'h04, 32'h0);
    chk("status", 48'(rd), 48'h501);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    outs(48'h0, 1'b1);
    chk("wait at rest", 48'(avs_waitrequest), 48'h1);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 6'h04, 32'h0);
    chk("status after reset", 48'(rd), 48'h1);
    bus(1'b0, 6'h18, 32'h0);
    chk("input after reset", 48'(rd), 48'h0);
    final_report();
  end

  // Watchdog against a hang anywhere in the run.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
